// ### src/fps_pkg.sv
// shared constants and types of the program/erase suspend sequencer
// assumes a 20 MHz core clock and a serial command interface in mode 0 or 3
package fps_pkg;

	// ==============================================================
	// opcodes and serial framing
	localparam logic [7:0] OP_SUSPEND = 8'hb0;
	localparam logic [7:0] OP_RESUME = 8'hd0;
	localparam logic [3:0] BITS_PER_OPCODE = 4'h8;
	localparam int SECTOR_W = 6;

	// ==============================================================
	// timing: latencies are maxima, so cycle counts round down
	localparam int CLK_PERIOD_NS = 50;
	localparam int SUSPEND_LATENCY_TIME_NS = 20000;
	localparam int RESUME_LATENCY_TIME_NS = 20000;
	localparam int LAT_W = 9;
	// the pin path (three flops, filter, edge detect) eats into the suspend latency,
	// so its cycles come off the count and the limit holds from the select pin itself
	localparam int PIN_PATH_CYC = 8;
	localparam logic [LAT_W-1:0] SUSP_CYC =
		LAT_W'((SUSPEND_LATENCY_TIME_NS / CLK_PERIOD_NS - PIN_PATH_CYC) < 1 ? 1 :
		(SUSPEND_LATENCY_TIME_NS / CLK_PERIOD_NS - PIN_PATH_CYC));
	localparam logic [LAT_W-1:0] RES_CYC =
		LAT_W'((RESUME_LATENCY_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (RESUME_LATENCY_TIME_NS / CLK_PERIOD_NS));

	// ==============================================================
	// pin synchroniser lanes and their reset levels
	localparam int PIN_SCK = 0;
	localparam int PIN_CS_N = 1;
	localparam int PIN_SI = 2;
	localparam int PIN_RST_N = 3;
	localparam logic [3:0] PIN_INIT = 4'he;

	// ==============================================================
	// command classes, supplied by the opcode decoder
	typedef enum logic [3:0] {
		CLS_OTHER,
		CLS_READ_ARRAY,
		CLS_READ_BUF,
		CLS_BUF_A_WRITE,
		CLS_BUF_B_WRITE,
		CLS_PROG_NO_ERASE,
		CLS_PROG_ERASE,
		CLS_ERASE,
		CLS_PROT_CHANGE,
		CLS_PROT_READ,
		CLS_STATUS_READ,
		CLS_SW_RESET,
		CLS_SUSPEND,
		CLS_RESUME
	} fps_class_type;

	// kind of erase that the array engine is running
	typedef enum logic [1:0] {
		ERS_PAGE,
		ERS_BLOCK,
		ERS_SECTOR
	} fps_erase_type;

	// program context reported by the array engine
	typedef struct packed {
		logic active;
		logic buf_b;
		logic [SECTOR_W-1:0] sector;
	} fps_prog_type;

	// erase context reported by the array engine
	typedef struct packed {
		logic active;
		fps_erase_type kind;
		logic [SECTOR_W-1:0] sector;
	} fps_erase_ctx_type;

	// status bits seen by status register reads
	typedef struct packed {
		logic ready;
		logic buf_a_prog_suspended;
		logic buf_b_prog_suspended;
		logic erase_suspended_flag;
	} fps_status_type;

endpackage

// ### src/fps_pin_sync.sv
// three-stage synchroniser for the serial pins and the reset pin
// assumes asynchronous inputs; a level is taken once stages two and three agree
module fps_pin_sync
	import fps_pkg::*;
#(
	parameter logic [3:0] INIT = PIN_INIT
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// raw pins and filtered levels
	input wire logic [3:0] pin_raw,
	output logic [3:0] pin_level
);

	// ==============================================================
	// one lane per pin
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : lane
			logic s1_reg; // first stage, read only by s2
			logic s2_reg;
			logic s3_reg;
			// shift chain, reset to the pin's idle level
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					s1_reg <= INIT[g];
					s2_reg <= INIT[g];
					s3_reg <= INIT[g];
				end else begin
					s1_reg <= pin_raw[g];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
				end
			end
			// accept a change only when two stages agree, filtering a one-cycle glitch
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					pin_level[g] <= INIT[g];
				end else if (s2_reg == s3_reg) begin
					pin_level[g] <= s3_reg;
				end
			end
		end
	endgenerate

endmodule

// ### src/fps_suspend.sv
// program/erase suspend sequencer of a two-buffer serial flash
// assumes an array engine that pauses a context while its hold is high,
// and an opcode decoder that classes the captured opcode in the same cycle

// Notes on behaviour
// - suspend is one opcode byte, rest ignored
// - halt running operation within suspend latency
// - set matching suspend flag, report ready
// - suspension covers only the one sector
// - reads of suspended sector give undefined data
// - continuous read undefined while inside suspended sector
// - program into erase-suspended sector aborts
// - program elsewhere during erase suspend, suspendable
// - reset during sector erase suspend loses whole sector
// - reset during page suspend loses only page
// - array and buffer reads always allowed
// - buffer writes blocked for suspended buffer only
// - program without erase only during erase suspend
// - erasing and with-erase programs refused when suspended
// - protection changes refused, protection read allowed
// - status reads served during suspend
// - resume opcode clears flag, reports busy
// - resume continues program before erase
// - suspend ignored while resume still restarting
module fps_suspend
	import fps_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// serial pins and hardware reset pin, asynchronous
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic reset_pin_n,
	// opcode decoder handshake
	output logic [7:0] opcode,
	output logic opcode_valid,
	input wire fps_class_type cmd_class,
	output logic cmd_permit,
	output logic cmd_permit_valid,
	// array engine contexts
	input wire fps_prog_type prog_ctx,
	input wire fps_erase_ctx_type erase_ctx,
	input wire logic prog_start,
	output logic prog_hold,
	output logic erase_hold,
	output logic prog_abort,
	// abandon pulses after a reset during suspend
	output logic sector_lost,
	output logic page_lost,
	// read address check
	input wire logic [SECTOR_W-1:0] rd_sector,
	output logic rd_undefined,
	// status bits
	output fps_status_type status
);

	// ==============================================================
	// pin synchronisers and edge detection
	logic [3:0] pin_level; // filtered pin levels
	logic sck_prev_reg;
	logic cs_prev_reg;
	logic rst_prev_reg;
	logic sck_rise; // sample point for modes 0 and 3
	logic cs_rise; // end of a command
	logic rst_fall; // hardware reset pin asserted

	fps_pin_sync u_sync (
		.clk(clk),
		.reset(reset),
		.pin_raw({reset_pin_n, si, cs_n, sck}),
		.pin_level(pin_level)
	);

	// previous levels for edge detection
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sck_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
			rst_prev_reg <= 1'b1;
		end else begin
			sck_prev_reg <= pin_level[PIN_SCK];
			cs_prev_reg <= pin_level[PIN_CS_N];
			rst_prev_reg <= pin_level[PIN_RST_N];
		end
	end

	assign sck_rise = pin_level[PIN_SCK] & ~sck_prev_reg;
	assign cs_rise = pin_level[PIN_CS_N] & ~cs_prev_reg;
	assign rst_fall = ~pin_level[PIN_RST_N] & rst_prev_reg;

	// ==============================================================
	// opcode capture
	logic [3:0] bit_cnt_reg; // saturates once the opcode is in
	logic [7:0] shift_reg;
	fps_class_type class_reg; // class of the current command
	logic have_op_reg; // a full opcode arrived in this frame

	// shift the first byte in; later bytes are ignored, so no address is needed
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			opcode <= 8'h00;
			opcode_valid <= 1'b0;
		end else begin
			opcode_valid <= 1'b0;
			if (pin_level[PIN_CS_N]) begin
				bit_cnt_reg <= 4'h0;
			end else if (sck_rise && bit_cnt_reg != BITS_PER_OPCODE) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				shift_reg <= {shift_reg[6:0], pin_level[PIN_SI]};
				if (bit_cnt_reg == BITS_PER_OPCODE - 4'h1) begin
					opcode <= {shift_reg[6:0], pin_level[PIN_SI]};
					opcode_valid <= 1'b1;
				end
			end
		end
	end

	// remember the class until the frame ends
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			class_reg <= CLS_OTHER;
			have_op_reg <= 1'b0;
		end else if (opcode_valid) begin
			class_reg <= (opcode == OP_SUSPEND) ? CLS_SUSPEND :
				(opcode == OP_RESUME) ? CLS_RESUME : cmd_class;
			have_op_reg <= 1'b1;
		end else if (cs_rise) begin
			have_op_reg <= 1'b0;
		end
	end

	// ==============================================================
	// command permission while suspended
	logic any_susp; // some context is suspended
	logic permit_now;

	assign any_susp = status.buf_a_prog_suspended | status.buf_b_prog_suspended |
		status.erase_suspended_flag;

	// table of what stays legal in each suspend state
	always_comb begin
		permit_now = 1'b1;
		if (any_susp) begin
			case (cmd_class)
				CLS_READ_ARRAY, CLS_READ_BUF: permit_now = 1'b1;
				CLS_BUF_A_WRITE: permit_now = ~status.buf_a_prog_suspended;
				CLS_BUF_B_WRITE: permit_now = ~status.buf_b_prog_suspended;
				CLS_PROG_NO_ERASE: permit_now = ~status.buf_a_prog_suspended &
					~status.buf_b_prog_suspended;
				CLS_PROG_ERASE, CLS_ERASE: permit_now = 1'b0;
				CLS_PROT_CHANGE: permit_now = 1'b0;
				CLS_PROT_READ: permit_now = 1'b1;
				CLS_STATUS_READ: permit_now = 1'b1;
				default: permit_now = 1'b1;
			endcase
		end
	end

	// answer one cycle after the opcode; the engine discards refused commands
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmd_permit <= 1'b1;
			cmd_permit_valid <= 1'b0;
		end else begin
			cmd_permit_valid <= opcode_valid;
			if (opcode_valid) begin
				cmd_permit <= permit_now;
			end
		end
	end

	// ==============================================================
	// suspend and resume sequencing
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SUSP_WAIT,
		ST_RES_WAIT
	} fps_state_type;

	fps_state_type state_reg;
	logic [LAT_W-1:0] lat_reg; // latency countdown
	logic target_prog_reg; // context being suspended or resumed
	logic prog_run; // program running and not held
	logic erase_run; // erase running and not held
	logic suspend_cmd;
	logic resume_cmd;
	logic reset_evt; // software reset command or reset pin
	logic [SECTOR_W-1:0] prog_sector_reg; // sector of suspended program
	logic [SECTOR_W-1:0] erase_sector_reg; // sector of suspended erase
	fps_erase_type erase_kind_reg;

	assign prog_run = prog_ctx.active & ~prog_hold;
	assign erase_run = erase_ctx.active & ~erase_hold;
	assign suspend_cmd = cs_rise & have_op_reg & class_reg == CLS_SUSPEND;
	assign resume_cmd = cs_rise & have_op_reg & class_reg == CLS_RESUME;
	assign reset_evt = (cs_rise & have_op_reg & class_reg == CLS_SW_RESET) | rst_fall;

	// state machine; reset abandons any pending step
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			lat_reg <= '0;
			target_prog_reg <= 1'b0;
		end else if (reset_evt) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					// nothing running means nothing to suspend
					if (suspend_cmd && (prog_run || erase_run)) begin
						state_reg <= ST_SUSP_WAIT;
						lat_reg <= SUSP_CYC;
						target_prog_reg <= prog_run;
					end else if (resume_cmd && any_susp) begin
						state_reg <= ST_RES_WAIT;
						lat_reg <= RES_CYC;
						// program resumes ahead of an erase
						target_prog_reg <= status.buf_a_prog_suspended |
							status.buf_b_prog_suspended;
					end
				end
				ST_SUSP_WAIT: begin
					lat_reg <= lat_reg - 1'b1;
					if (lat_reg == 1) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_RES_WAIT: begin
					// a new suspend here is simply dropped
					lat_reg <= lat_reg - 1'b1;
					if (lat_reg == 1) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	logic susp_done; // last cycle of suspend latency
	assign susp_done = state_reg == ST_SUSP_WAIT && lat_reg == 1;

	// holds and flags; the context finishing naturally is not expected mid-wait
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prog_hold <= 1'b0;
			erase_hold <= 1'b0;
			status.buf_a_prog_suspended <= 1'b0;
			status.buf_b_prog_suspended <= 1'b0;
			status.erase_suspended_flag <= 1'b0;
		end else if (reset_evt) begin
			prog_hold <= 1'b0;
			erase_hold <= 1'b0;
			status.buf_a_prog_suspended <= 1'b0;
			status.buf_b_prog_suspended <= 1'b0;
			status.erase_suspended_flag <= 1'b0;
		end else if (susp_done) begin
			if (target_prog_reg) begin
				prog_hold <= 1'b1;
				status.buf_a_prog_suspended <= ~prog_ctx.buf_b;
				status.buf_b_prog_suspended <= prog_ctx.buf_b;
			end else begin
				erase_hold <= 1'b1;
				status.erase_suspended_flag <= 1'b1;
			end
		end else if (resume_cmd && state_reg == ST_IDLE && any_susp) begin
			if (status.buf_a_prog_suspended || status.buf_b_prog_suspended) begin
				prog_hold <= 1'b0;
				status.buf_a_prog_suspended <= 1'b0;
				status.buf_b_prog_suspended <= 1'b0;
			end else begin
				erase_hold <= 1'b0;
				status.erase_suspended_flag <= 1'b0;
			end
		end
	end

	// remember which sector each suspended context owns
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prog_sector_reg <= '0;
			erase_sector_reg <= '0;
			erase_kind_reg <= ERS_PAGE;
		end else if (susp_done) begin
			if (target_prog_reg) begin
				prog_sector_reg <= prog_ctx.sector;
			end else begin
				erase_sector_reg <= erase_ctx.sector;
				erase_kind_reg <= erase_ctx.kind;
			end
		end
	end

	// ready while nothing runs and no latency is pending
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status.ready <= 1'b1;
		end else begin
			status.ready <= ~(prog_run | erase_run) & state_reg == ST_IDLE;
		end
	end

	// ==============================================================
	// reads and programs against suspended sectors
	// re-evaluated every cycle so an incrementing read address follows it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_undefined <= 1'b0;
		end else begin
			rd_undefined <= (status.erase_suspended_flag && rd_sector == erase_sector_reg) ||
				((status.buf_a_prog_suspended || status.buf_b_prog_suspended) &&
				rd_sector == prog_sector_reg);
		end
	end

	// a program may not start in the sector whose erase is paused
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prog_abort <= 1'b0;
		end else begin
			prog_abort <= prog_start & status.erase_suspended_flag &
				prog_ctx.sector == erase_sector_reg;
		end
	end

	// ==============================================================
	// damage report when a reset ends a suspension
	// block and page erases touch only their pages, so they report page loss
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sector_lost <= 1'b0;
			page_lost <= 1'b0;
		end else begin
			sector_lost <= reset_evt & status.erase_suspended_flag &
				erase_kind_reg == ERS_SECTOR;
			page_lost <= reset_evt & (status.buf_a_prog_suspended | status.buf_b_prog_suspended |
				(status.erase_suspended_flag & erase_kind_reg != ERS_SECTOR));
		end
	end

endmodule

// ### testbench/fps_suspend_sva.sv
// checker of the suspend sequencer, bound to its top module
// assumes the clk domain only; pin-side timing is judged by the bench
module fps_suspend_chk
	import fps_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// decoder handshake
	input wire logic opcode_valid,
	input wire fps_class_type cmd_class,
	input wire logic cmd_permit,
	input wire logic cmd_permit_valid,
	// engine side
	input wire fps_prog_type prog_ctx,
	input wire fps_erase_ctx_type erase_ctx,
	input wire logic prog_start,
	input wire logic prog_hold,
	input wire logic erase_hold,
	input wire logic prog_abort,
	// reads and status
	input wire logic [SECTOR_W-1:0] rd_sector,
	input wire logic rd_undefined,
	input wire fps_status_type status
);
	timeunit 1ns;
	timeprecision 1ns;
	// ======
	// single domain, so clocking and disable are shared
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// any flag set means the permit table applies
	wire susp = status.buf_a_prog_suspended | status.buf_b_prog_suspended | status.erase_suspended_flag;

	// ======
	// permit answer
	property p_handshake;
		opcode_valid |=> cmd_permit_valid && !opcode_valid;
	endproperty
	a_handshake: assert property (p_handshake) else $error("permit answer missing");
	property p_reads;
		opcode_valid && cmd_class inside {CLS_READ_ARRAY, CLS_READ_BUF, CLS_PROT_READ, CLS_STATUS_READ} |=> cmd_permit;
	endproperty
	a_reads: assert property (p_reads) else $error("read class refused");
	property p_refused;
		opcode_valid && susp && cmd_class inside {CLS_PROG_ERASE, CLS_ERASE, CLS_PROT_CHANGE} |=> !cmd_permit;
	endproperty
	a_refused: assert property (p_refused) else $error("erase class allowed in suspend");
	property p_buf;
		opcode_valid && (status.buf_a_prog_suspended && cmd_class == CLS_BUF_A_WRITE
			|| status.buf_b_prog_suspended && cmd_class == CLS_BUF_B_WRITE) |=> !cmd_permit;
	endproperty
	a_buf: assert property (p_buf) else $error("suspended buffer written");
	property p_no_erase_prog;
		opcode_valid && cmd_class == CLS_PROG_NO_ERASE
			|=> cmd_permit == !($past(status.buf_a_prog_suspended) || $past(status.buf_b_prog_suspended));
	endproperty
	a_no_erase_prog: assert property (p_no_erase_prog) else $error("program without erase permit wrong");

	// ======
	// engine holds, aborts and reads
	property p_erase_hold;
		$rose(status.erase_suspended_flag) |-> erase_hold;
	endproperty
	a_erase_hold: assert property (p_erase_hold) else $error("erase flag without hold");
	property p_prog_hold;
		$rose(status.buf_a_prog_suspended || status.buf_b_prog_suspended) |-> prog_hold;
	endproperty
	a_prog_hold: assert property (p_prog_hold) else $error("program flag without hold");
	property p_abort;
		prog_start && status.erase_suspended_flag && prog_ctx.sector == erase_ctx.sector |=> prog_abort;
	endproperty
	a_abort: assert property (p_abort) else $error("program into suspended sector ran");
	property p_undef;
		(status.erase_suspended_flag && rd_sector == erase_ctx.sector) ##1 status.erase_suspended_flag |-> rd_undefined;
	endproperty
	a_undef: assert property (p_undef) else $error("suspended sector read as defined");
endmodule

bind fps_suspend fps_suspend_chk u_chk (.clk, .reset, .opcode_valid, .cmd_class, .cmd_permit, .cmd_permit_valid,
	.prog_ctx, .erase_ctx, .prog_start, .prog_hold, .erase_hold, .prog_abort, .rd_sector, .rd_undefined, .status);

// ### testbench/fps_host_model.sv
// host model driving the serial pins of the suspend sequencer
// assumes the core clock for pacing; link period is eight core cycles (400 ns)
module fps_host_model
	import fps_pkg::*;
(
	// core clock used for pacing
	input wire logic clk,
	// serial pins
	output logic sck,
	output logic cs_n,
	output logic si
);
	timeunit 1ns;
	timeprecision 1ns;
	// ======
	// idle link: clock parked low between frames, select high
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b1;
	end

	// ======
	// one frame, opcode msb first, optional trailing byte the device must ignore
	task automatic send(input logic [7:0] op, input logic [7:0] tail, input logic tl);
		logic [15:0] b;
		b = {op, tail};
		@(negedge clk) cs_n = 1'b0;
		for (int i = 0; i < (tl ? 16 : 8); i++) begin
			si = b[15 - i];
			repeat (4) @(negedge clk);
			sck = 1'b1;
			repeat (4) @(negedge clk);
			sck = 1'b0;
		end
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		// released data line has no pull, so show the inverse rather than a stale level
		si = ~si;
		repeat (8) @(negedge clk);
	endtask
endmodule

// ### testbench/flash_program_erase_suspend_test.sv
// self-checking bench of the program/erase suspend sequencer
// assumes the host model on the pins; the bench plays decoder and array engine
module flash_program_erase_suspend_test
	import fps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ======
	// design signals
	logic clk, reset, sck, cs_n, si, reset_pin_n, opcode_valid, cmd_permit, cmd_permit_valid;
	logic prog_start, prog_hold, erase_hold, prog_abort, sector_lost, page_lost, rd_undefined, last_perm;
	logic [7:0] opcode;
	logic [SECTOR_W-1:0] rd_sector;
	fps_class_type cmd_class;
	fps_prog_type prog_ctx;
	fps_erase_ctx_type erase_ctx;
	fps_status_type status;
	int n_errors = 0, comparisons = 0, cyc = 0, n_perm = 0, n_abort = 0, n_slost = 0, n_plost = 0;
	// permit table rows: class, expected permit as {idle, buf a, buf b, erase}
	typedef struct packed {fps_class_type c; logic [3:0] e;} fps_row_type;
	fps_row_type rows [10] = '{'{CLS_READ_ARRAY, 4'hf}, '{CLS_READ_BUF, 4'hf}, '{CLS_BUF_A_WRITE, 4'hb},
		'{CLS_BUF_B_WRITE, 4'hd}, '{CLS_PROG_NO_ERASE, 4'h9}, '{CLS_PROG_ERASE, 4'h8}, '{CLS_ERASE, 4'h8},
		'{CLS_PROT_CHANGE, 4'h8}, '{CLS_PROT_READ, 4'hf}, '{CLS_STATUS_READ, 4'hf}};

	fps_suspend dut (.clk, .reset, .sck, .cs_n, .si, .reset_pin_n, .opcode, .opcode_valid, .cmd_class, .cmd_permit,
		.cmd_permit_valid, .prog_ctx, .erase_ctx, .prog_start, .prog_hold, .erase_hold, .prog_abort, .sector_lost,
		.page_lost, .rd_sector, .rd_undefined, .status);
	fps_host_model host (.clk, .sck, .cs_n, .si);

	// ======
	// clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// pulse monitor; permit, abort and loss pulses are caught here so no test misses them
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cmd_permit_valid === 1'b1) begin
			n_perm <= n_perm + 1;
			last_perm <= cmd_permit;
		end
		if (prog_abort === 1'b1) n_abort <= n_abort + 1;
		if (sector_lost === 1'b1) n_slost <= n_slost + 1;
		if (page_lost === 1'b1) n_plost <= n_plost + 1;
		// a hang ends here
		if (cyc == 20000) begin
			n_errors++;
			end_of_test;
		end
	end

	// ======
	// helpers
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("ERROR at %0t: %s", $time, m);
		end
	endtask
	task automatic wait_st(input logic [3:0] m, input logic [3:0] v, output int n);
		n = 0;
		while ((status & m) !== v && n < 1000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// one classed command; the permit answer is taken from the monitor
	task automatic cmd(input logic [7:0] op, input fps_class_type c, input logic exp);
		int k;
		k = n_perm;
		cmd_class = c;
		host.send(op, 8'h00, 1'b0);
		chk(n_perm == k + 1 && last_perm === exp && opcode === op, "permit");
	endtask
	// suspend with a trailing byte; flag mask m names the expected context
	task automatic suspend(input logic [3:0] m);
		int n;
		cmd_class = CLS_SUSPEND;
		host.send(OP_SUSPEND, 8'h3c, 1'b1);
		wait_st(m, m, n);
		// n starts eight cycles after the select pin rose, so the limit is measured from the pin
		chk(n + 8 <= SUSPEND_LATENCY_TIME_NS / CLK_PERIOD_NS && opcode === OP_SUSPEND &&
			(m == 4'h1 ? erase_hold : prog_hold) === 1'b1, "suspend");
		repeat (2) @(negedge clk);
		chk(status.ready === 1'b1, "not ready");
	endtask
	task automatic resume(input logic [3:0] m);
		int n;
		cmd_class = CLS_RESUME;
		host.send(OP_RESUME, 8'h00, 1'b0);
		wait_st(m, 4'h0, n);
		repeat (2) @(negedge clk);
		chk(n < 40 && status.ready === 1'b0, "resume");
	endtask
	task automatic pulse_start;
		prog_start = 1'b1;
		@(negedge clk);
		prog_start = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic end_of_test;
		$display("n_errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ======
	// main sequence
	initial begin
		reset = 1'b1;
		reset_pin_n = 1'b1;
		cmd_class = CLS_OTHER;
		prog_ctx = '0;
		erase_ctx = '0;
		prog_start = 1'b0;
		rd_sector = '0;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		chk(status === 4'h8 && cmd_permit === 1'b1 && opcode === 8'h00, "reset values");
		// suspend with nothing running
		cmd_class = CLS_SUSPEND;
		host.send(OP_SUSPEND, 8'h00, 1'b0);
		repeat (450) @(negedge clk);
		chk(status === 4'h8 && erase_hold === 1'b0 && prog_hold === 1'b0, "idle suspend acted");
		// permit table in each state: idle, buffer a, buffer b, erase
		for (int s = 3; s >= 0; s--) begin
			prog_ctx = '{s == 2 || s == 1, s == 1, 6'h05};
			erase_ctx = '{s == 0, ERS_SECTOR, 6'h03};
			if (s < 3) suspend(4'h1 << s);
			foreach (rows[i]) cmd(8'h40 + 8'(i), rows[i].c, rows[i].e[s]);
			// walk the read address across sectors 2..5: program suspends own sector 5, erase owns 3
			if (s < 3) begin
				for (int r = 2; r < 6; r++) begin
					rd_sector = 6'(r);
					repeat (2) @(negedge clk);
					chk(rd_undefined === (r == (s == 0 ? 3 : 5)), "read undefined");
				end
			end
			if (s < 3) begin
				resume(4'h1 << s);
				cmd_class = CLS_SUSPEND;
				host.send(OP_SUSPEND, 8'h00, 1'b0);
				repeat (450) @(negedge clk);
				chk(status[2:0] === 3'b000, "suspend while resuming");
			end
		end
		// erase suspended: program into it aborts, elsewhere it runs and suspends
		suspend(4'h1);
		prog_ctx = '{1'b1, 1'b0, 6'h03};
		pulse_start;
		chk(n_abort == 1, "no abort");
		prog_ctx = '{1'b1, 1'b1, 6'h07};
		pulse_start;
		suspend(4'h2);
		chk(status[2:0] === 3'b011 && n_abort == 1, "both flags");
		resume(4'h2);
		chk(status.erase_suspended_flag === 1'b1, "erase resumed first");
		repeat (RES_CYC + 10) @(negedge clk);
		prog_ctx.active = 1'b0;
		resume(4'h1);
		repeat (RES_CYC + 10) @(negedge clk);
		// pin reset in sector erase suspend, software reset in page erase suspend
		suspend(4'h1);
		reset_pin_n = 1'b0;
		repeat (10) @(negedge clk);
		reset_pin_n = 1'b1;
		repeat (10) @(negedge clk);
		chk(n_slost == 1 && n_plost == 0 && status[2:0] === 3'b000, "pin reset");
		erase_ctx.kind = ERS_PAGE;
		suspend(4'h1);
		cmd_class = CLS_SW_RESET;
		host.send(8'hf0, 8'h00, 1'b0);
		repeat (10) @(negedge clk);
		chk(n_slost == 1 && n_plost == 1 && status[2:0] === 3'b000, "soft reset");
		end_of_test;
	end
endmodule
